// ---- rtl/mhub_hub.sv ----
// Repeater hub: source selection, repeat, collision jam and indicators
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mhub_hub
    import mhub_pkg::*;
#(
    parameter int JAM_BITS_P = JAM_BITS,
    parameter int COL_BITS_P = COL_IND_BITS
)
(
    input wire logic pclk, // System clock, 50 MHz
    input wire logic presetn, // Async reset, low
    mhub_link_if.hub lnk, // Channel lines
    input wire logic uplink_disable, // Jumper, high isolates channel zero
    output logic [NUM_CH-1:0] act_ind, // Per-channel activity
    output logic [NUM_CH-1:0] col_ind, // Per-channel collision pulse
    output logic jam_indicator, // Jam in progress
    output logic config_fail_indicator // Latched configuration failure
);
    localparam int JAM_CYC = JAM_BITS_P * BIT_CYC;
    localparam logic [15:0] COL_CYC = 16'(COL_BITS_P * BIT_CYC);

    mhub_state_t state;
    mhub_state_t next_state;
    logic [3:0] src;
    logic [3:0] next_src;
    logic [15:0] jam_cnt;
    logic [15:0] next_jam_cnt;
    logic [4:0] half_cnt;
    logic [4:0] next_half_cnt;
    logic jam_tog;
    logic next_jam_tog;
    logic [NUM_CH-1:0] down_q;
    logic [NUM_CH-1:0] next_down;
    logic [NUM_CH-1:0] act_q;
    logic [NUM_CH-1:0] next_act_ind;
    logic [NUM_CH-1:0] col_set;
    logic [NUM_CH-1:0] lvl;
    logic [NUM_CH-1:0] raw_act;
    logic [NUM_CH-1:0] act;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] others;
    logic [NUM_CH-1:0] drv;
    logic multi;
    logic [3:0] first;

    // Jumper capture and failure latch
    logic [2:0] jsync;
    logic [1:0] settle;
    logic strap;
    logic strap_done;
    logic fail;
    logic [1:0] next_settle;
    logic next_strap;
    logic next_strap_done;
    logic next_fail;

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++)
        begin : g_ch
            mhub_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .line_in(lnk.up[i]),
                .col_set(col_set[i]),
                .col_cyc(COL_CYC),
                .level(lvl[i]),
                .act(raw_act[i]),
                .col_ind(col_ind[i])
            );
        end
    endgenerate

    // Uplink enabled only once the strap is known and it is not fitted
    assign en = {{(NUM_CH - 1){1'b1}}, strap_done & ~strap};
    assign act = raw_act & en;
    // Two or more set bits
    assign multi = |(act & (act - 9'(1)));

    always_comb
    begin
        first = 4'h0;
        for (int k = NUM_CH - 1; k >= 0; k--)
        begin
            if (act[k])
                first = 4'(k);
        end
    end

    always_comb
    begin
        others = act;
        others[src] = 1'b0;
    end

    // Jumper strap, settled after release then watched for changes
    always_comb
    begin
        next_settle = settle;
        next_strap = strap;
        next_strap_done = strap_done;
        next_fail = fail;
        if (!strap_done)
        begin
            if (settle == 2'(STRAP_SETTLE))
            begin
                next_strap = jsync[2];
                next_strap_done = 1'b1;
            end
            else
                next_settle = settle + 2'h1;
        end
        else if (jsync[1] == jsync[2] && jsync[2] != strap)
            next_fail = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jsync <= 3'h0;
            settle <= 2'h0;
            strap <= 1'b0;
            strap_done <= 1'b0;
            fail <= 1'b0;
        end
        else
        begin
            jsync <= {jsync[1:0], uplink_disable};
            settle <= next_settle;
            strap <= next_strap;
            strap_done <= next_strap_done;
            fail <= next_fail;
        end
    end

    // Repeat and jam sequencing
    always_comb
    begin
        next_state = state;
        next_src = src;
        next_jam_cnt = jam_cnt;
        col_set = '0;
        unique case (state)
            HUB_IDLE:
            begin
                if (multi)
                begin
                    next_state = HUB_JAM;
                    next_jam_cnt = 16'(JAM_CYC - 1);
                    col_set = act;
                end
                else if (|act)
                begin
                    next_state = HUB_REPEAT;
                    next_src = first;
                end
            end
            HUB_REPEAT:
            begin
                // A talker starting as the source falls quiet is a new source, not a collision
                if (|others && act[src])
                begin
                    next_state = HUB_JAM;
                    next_jam_cnt = 16'(JAM_CYC - 1);
                    col_set = act;
                end
                else if (!act[src])
                    next_state = HUB_IDLE;
            end
            HUB_JAM:
            begin
                if (jam_cnt == 16'h0000)
                    next_state = HUB_IDLE;
                else
                    next_jam_cnt = jam_cnt - 16'h0001;
            end
        endcase
    end

    // Jam pattern is a stream of ones, toggling each half bit
    always_comb
    begin
        next_half_cnt = half_cnt;
        next_jam_tog = jam_tog;
        if (state != HUB_JAM)
        begin
            next_half_cnt = 5'h00;
            next_jam_tog = 1'b1;
        end
        else if (half_cnt == 5'(HALF_CYC - 1))
        begin
            next_half_cnt = 5'h00;
            next_jam_tog = ~jam_tog;
        end
        else
            next_half_cnt = half_cnt + 5'h01;
    end

    always_comb
    begin
        drv = '0;
        next_down = '0;
        for (int k = 0; k < NUM_CH; k++)
        begin
            if (state == HUB_REPEAT && en[k] && 4'(k) != src)
            begin
                drv[k] = 1'b1;
                next_down[k] = lvl[src];
            end
            else if (state == HUB_JAM && en[k])
            begin
                drv[k] = 1'b1;
                next_down[k] = jam_tog;
            end
        end
        next_act_ind = act | drv;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= HUB_IDLE;
            src <= 4'h0;
            jam_cnt <= 16'h0000;
            half_cnt <= 5'h00;
            jam_tog <= 1'b1;
            down_q <= '0;
            act_q <= '0;
        end
        else
        begin
            state <= next_state;
            src <= next_src;
            jam_cnt <= next_jam_cnt;
            half_cnt <= next_half_cnt;
            jam_tog <= next_jam_tog;
            down_q <= next_down;
            act_q <= next_act_ind;
        end
    end

    assign lnk.down = down_q;
    assign act_ind = act_q;
    assign jam_indicator = (state == HUB_JAM);
    assign config_fail_indicator = fail;
endmodule
`default_nettype wire

// ---- rtl/mhub_pkg.sv ----
// Shared constants and types for the segment repeater hub and its nodes
// Function
// - Nine channels: uplink zero, segments one-eight
// - Manchester signalling at 1.25 Mb/s everywhere
// - CSMA/CD: nodes defer while line busy
// - Uplink disable isolates channel zero completely
// - Per-channel activity indicator while transmitting
// - Per-channel collision indicator pulses briefly
// - Jam indicator active while jamming
// - Config failure indicator latched until reset
// - Reset restores initial state, clears failure
// - Collision makes hub jam all enabled channels
// - Nodes retry after randomized backoff
// - At most fifty nodes per segment
// - Detect, reclock, repeat to other channels
// - Per-channel collision detect, jam propagates
package mhub_pkg;
    localparam int NUM_CH = 9;
    localparam int UPLINK_CH = 0;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_NS = 800;
    localparam int BIT_CYC = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int QUARTER_CYC = BIT_CYC / 4;
    localparam int QUIET_BITS = 2;
    localparam int QUIET_CYC = QUIET_BITS * BIT_CYC;
    localparam int JAM_BITS = 32;
    localparam int COL_IND_BITS = 8;
    localparam int FRAME_DATA_BITS = 8;
    localparam int MAX_NODES_PER_SEG = 50;
    localparam int STRAP_SETTLE = 3;
    // APB register map of the node controller
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int ST_TXDONE = 0;
    localparam int ST_RXDONE = 1;
    localparam int ST_COL = 2;
    localparam logic [7:0] RST_TXDATA = 8'h00;
    localparam logic [2:0] RST_MASK = 3'h0;
    localparam logic [2:0] RST_STATUS = 3'h0;
    localparam logic [7:0] LFSR_SEED = 8'h5A;

    typedef enum logic [1:0] {HUB_IDLE, HUB_REPEAT, HUB_JAM} mhub_state_t;
    typedef enum logic [1:0] {NODE_IDLE, NODE_TX, NODE_RX, NODE_WAIT} mhub_node_state_t;
endpackage

// ---- rtl/mhub_link_if.sv ----
// Channel wiring between the hub and the nodes on its segments
`timescale 1ns/1ps
`default_nettype none
interface mhub_link_if;
    import mhub_pkg::*;
    wire [NUM_CH-1:0] up; // Node to hub, one line per channel
    logic [NUM_CH-1:0] down; // Hub to nodes, one line per channel
    modport hub (input up, output down);
    modport node (output up, input down);
endinterface
`default_nettype wire

// ---- rtl/mhub_chan.sv ----
// Line receiver: synchroniser, activity detect and collision pulse stretcher
`timescale 1ns/1ps
`default_nettype none
module mhub_chan
    import mhub_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, low
    input wire logic line_in, // Raw line level
    input wire logic col_set, // Start collision pulse
    input wire logic [15:0] col_cyc, // Pulse length in cycles
    output logic level, // Filtered line level
    output logic act, // Transitions seen recently
    output logic col_ind // Collision indicator
);
    logic [2:0] sync;
    logic [7:0] quiet;
    logic [15:0] col;
    logic next_level;
    logic [7:0] next_quiet;
    logic [15:0] next_col;

    always_comb
    begin
        // A change counts once second and third stages agree
        next_level = (sync[1] == sync[2]) ? sync[2] : level;
        if (next_level != level)
            next_quiet = 8'(QUIET_CYC);
        else if (quiet != 8'h00)
            next_quiet = quiet - 8'h01;
        else
            next_quiet = quiet;
        if (col_set)
            next_col = col_cyc;
        else if (col != 16'h0000)
            next_col = col - 16'h0001;
        else
            next_col = col;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync <= 3'h0;
            level <= 1'b0;
            quiet <= 8'h00;
            col <= 16'h0000;
        end
        else
        begin
            sync <= {sync[1:0], line_in};
            level <= next_level;
            quiet <= next_quiet;
            col <= next_col;
        end
    end

    assign act = (quiet != 8'h00);
    assign col_ind = (col != 16'h0000);
endmodule
`default_nettype wire

// ---- rtl/mhub_node.sv ----
// Network node controller: APB registers, Manchester framer, CSMA/CD backoff
`timescale 1ns/1ps
`default_nettype none
module mhub_node
    import mhub_pkg::*;
#(
    parameter int CH = 1
)
(
    input wire logic pclk, // System clock, 50 MHz
    input wire logic presetn, // Async reset, low
    mhub_link_if.node lnk, // Channel lines
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic irq // Interrupt, high level
);
    mhub_node_state_t state;
    mhub_node_state_t next_state;
    logic [7:0] txdata;
    logic [7:0] next_txdata;
    logic [7:0] rxdata;
    logic [7:0] next_rxdata;
    logic [2:0] status;
    logic [2:0] next_status;
    logic [2:0] mask;
    logic [2:0] next_mask;
    logic pend;
    logic next_pend;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [8:0] shreg;
    logic [8:0] next_shreg;
    logic half;
    logic next_half;
    logic txline;
    logic next_txline;
    logic [7:0] lfsr;
    logic [7:0] next_lfsr;
    logic [31:0] next_prdata;
    logic rl;
    logic rl_d;
    logic ract;
    logic wr;
    logic mapped;
    logic [2:0] sets;

    mhub_chan u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(lnk.down[CH]),
        .col_set(1'b0),
        .col_cyc(16'h0000),
        .level(rl),
        .act(ract),
        .col_ind()
    );

    assign mapped = paddr == REG_CTRL || paddr == REG_TXDATA || paddr == REG_RXDATA
        || paddr == REG_STATUS || paddr == REG_MASK;
    assign wr = psel && penable && pwrite && mapped;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_bitn = bitn;
        next_shreg = shreg;
        next_half = half;
        next_txline = txline;
        next_rxdata = rxdata;
        next_pend = pend;
        sets = 3'h0;
        next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        if (cnt != 16'h0000)
            next_cnt = cnt - 16'h0001;
        unique case (state)
            NODE_IDLE:
            begin
                if (rl && !rl_d)
                begin
                    next_state = NODE_RX;
                    next_cnt = 16'(BIT_CYC + QUARTER_CYC - 1);
                    next_bitn = 4'h0;
                end
                else if (pend && !ract)
                begin
                    next_state = NODE_TX;
                    next_shreg = {1'b1, txdata};
                    next_txline = 1'b1;
                    next_half = 1'b0;
                    next_bitn = 4'h0;
                    next_cnt = 16'(HALF_CYC - 1);
                end
            end
            NODE_TX:
            begin
                if (ract)
                begin
                    // Hub is jamming this segment
                    next_state = NODE_WAIT;
                    next_txline = 1'b0;
                    next_cnt = 16'((32'(lfsr[3:0]) + 1) * BIT_CYC);
                    sets[ST_COL] = 1'b1;
                end
                else if (cnt == 16'h0000)
                begin
                    next_cnt = 16'(HALF_CYC - 1);
                    if (!half)
                    begin
                        next_half = 1'b1;
                        next_txline = ~shreg[8];
                    end
                    else if (bitn == 4'(FRAME_DATA_BITS))
                    begin
                        next_state = NODE_IDLE;
                        next_txline = 1'b0;
                        next_pend = 1'b0;
                        sets[ST_TXDONE] = 1'b1;
                    end
                    else
                    begin
                        next_half = 1'b0;
                        next_shreg = {shreg[7:0], 1'b0};
                        next_txline = shreg[7];
                        next_bitn = bitn + 4'h1;
                    end
                end
            end
            NODE_RX:
            begin
                if (cnt == 16'h0000)
                begin
                    next_shreg = {shreg[7:0], rl};
                    next_bitn = bitn + 4'h1;
                    next_cnt = 16'(BIT_CYC - 1);
                    if (bitn == 4'(FRAME_DATA_BITS - 1))
                    begin
                        next_state = NODE_WAIT;
                        next_rxdata = {shreg[6:0], rl};
                        next_cnt = 16'h0000;
                        sets[ST_RXDONE] = 1'b1;
                    end
                end
            end
            NODE_WAIT:
            begin
                // Backoff only runs while the line is quiet
                if (ract)
                    next_cnt = cnt;
                else if (cnt == 16'h0000)
                    next_state = NODE_IDLE;
            end
        endcase
        next_txdata = txdata;
        next_mask = mask;
        if (wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT])
            next_pend = 1'b1;
        if (wr && paddr == REG_TXDATA && !pend)
            next_txdata = pwdata[7:0];
        if (wr && paddr == REG_MASK)
            next_mask = pwdata[2:0];
        // Set wins over a write-one clear in the same cycle
        next_status = sets | status;
        if (wr && paddr == REG_STATUS)
            next_status = sets | (status & ~pwdata[2:0]);
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                REG_CTRL: next_prdata[CTRL_BUSY_BIT] = pend;
                REG_TXDATA: next_prdata[7:0] = txdata;
                REG_RXDATA: next_prdata[7:0] = rxdata;
                REG_STATUS: next_prdata[2:0] = status;
                REG_MASK: next_prdata[2:0] = mask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        else
            next_prdata = prdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= NODE_IDLE;
            cnt <= 16'h0000;
            bitn <= 4'h0;
            shreg <= 9'h000;
            half <= 1'b0;
            txline <= 1'b0;
            rxdata <= 8'h00;
            txdata <= RST_TXDATA;
            status <= RST_STATUS;
            mask <= RST_MASK;
            pend <= 1'b0;
            prdata <= 32'h0000_0000;
            rl_d <= 1'b0;
            lfsr <= LFSR_SEED ^ 8'(CH);
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            bitn <= next_bitn;
            shreg <= next_shreg;
            half <= next_half;
            txline <= next_txline;
            rxdata <= next_rxdata;
            txdata <= next_txdata;
            status <= next_status;
            mask <= next_mask;
            pend <= next_pend;
            prdata <= next_prdata;
            rl_d <= rl;
            lfsr <= next_lfsr;
        end
    end

    assign lnk.up[CH] = txline;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(status & mask);
endmodule
`default_nettype wire

// ---- sim/mhub_chk.sv ----
// Concurrent checks on the hub channel lines and indicators
`timescale 1ns/1ps
`default_nettype none
module mhub_chk
    import mhub_pkg::*;
#(
    parameter int JAM_BITS_P = JAM_BITS,
    parameter int COL_BITS_P = COL_IND_BITS
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic [NUM_CH-1:0] up, // Node lines
    input wire logic [NUM_CH-1:0] down, // Hub lines
    input wire logic uplink_disable, // Jumper
    input wire logic [NUM_CH-1:0] act_ind, // Activity
    input wire logic [NUM_CH-1:0] col_ind, // Collision pulses
    input wire logic jam_indicator, // Jam
    input wire logic config_fail_indicator // Failure
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int jam_cnt;
    int col_cnt;
    logic [3:0] age;
    // Age saturates so jumper moves during strap capture are not judged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jam_cnt <= 0;
            col_cnt <= 0;
            age <= 4'h0;
        end
        else
        begin
            jam_cnt <= jam_indicator ? jam_cnt + 1 : 0;
            col_cnt <= col_ind[1] ? col_cnt + 1 : 0;
            age <= (age == 4'hF) ? age : age + 4'h1;
        end
    end
    jam_drive_a: assert property ($rose(jam_indicator) |-> ##[1:25] $changed(down[8]))
        else $error("jam not driven on channel 8");
    jam_len_a: assert property ($fell(jam_indicator) |->
        jam_cnt >= JAM_BITS_P * BIT_CYC - 1 && jam_cnt <= JAM_BITS_P * BIT_CYC + 1)
        else $error("jam length wrong");
    col_len_a: assert property ($fell(col_ind[1]) |->
        col_cnt >= COL_BITS_P * BIT_CYC - 1 && col_cnt <= COL_BITS_P * BIT_CYC + 1)
        else $error("collision pulse length wrong");
    col_jam_a: assert property ($rose(col_ind[1]) |-> ##[0:3] jam_indicator)
        else $error("collision without jam");
    jam_cause_a: assert property ($rose(jam_indicator) |-> ##[0:3] $countones(col_ind) > 1)
        else $error("jam without two colliders");
    uplink_iso_a: assert property (uplink_disable && $past(uplink_disable, 5) &&
        !config_fail_indicator |-> !down[0])
        else $error("disabled uplink driven");
    cfg_hold_a: assert property (config_fail_indicator |=> config_fail_indicator)
        else $error("failure indicator dropped");
    cfg_set_a: assert property (age == 4'hF && $changed(uplink_disable) |->
        ##[1:8] config_fail_indicator)
        else $error("jumper change not flagged");
    act_on_a: assert property ($rose(up[1]) |-> ##[1:6] act_ind[1])
        else $error("activity missing");
    repeat_out_a: assert property (!jam_indicator && act_ind == '0 && $rose(up[1]) |->
        ##[1:8] down[2])
        else $error("frame not repeated");
endmodule
`default_nettype wire

// ---- sim/test_mhub.sv ----
// Self-checking bench: hub with a node on every channel
`timescale 1ns/1ps
`default_nettype none
module test_manchester_segment_repeater_hub
    import mhub_pkg::*;
;
    localparam int JB = 4;
    localparam int CB = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic uplink_disable = 1'b0;
    logic [NUM_CH-1:0] psel = '0;
    logic [NUM_CH-1:0] penable = '0;
    logic [NUM_CH-1:0] pwrite = '0;
    logic [7:0] paddr [NUM_CH] = '{default: 8'h00};
    logic [31:0] pwdata [NUM_CH] = '{default: 32'h0000_0000};
    wire logic [31:0] prdata [NUM_CH];
    wire logic [NUM_CH-1:0] pready, pslverr, irq, act_ind, col_ind;
    wire logic jam_indicator, config_fail_indicator;
    int fail_count = 0;
    int cmp_count = 0;
    logic jam_seen = 1'b0;
    logic [NUM_CH-1:0] col_seen = '0;
    logic [31:0] rd;
    logic er;

    always #10 pclk = ~pclk;
    mhub_link_if i_mhub_link_if ();
    mhub_hub #(.JAM_BITS_P(JB), .COL_BITS_P(CB)) i_mhub_hub (.pclk(pclk), .presetn(presetn),
        .lnk(i_mhub_link_if.hub), .uplink_disable(uplink_disable), .act_ind(act_ind),
        .col_ind(col_ind), .jam_indicator(jam_indicator),
        .config_fail_indicator(config_fail_indicator));
    for (genvar k = 0; k < NUM_CH; k++) // One node per segment, far below the limit
    begin : g_node
        mhub_node #(.CH(k)) i_mhub_node (.pclk(pclk), .presetn(presetn),
            .lnk(i_mhub_link_if.node), .psel(psel[k]), .penable(penable[k]),
            .pwrite(pwrite[k]), .paddr(paddr[k]), .pwdata(pwdata[k]), .prdata(prdata[k]),
            .pready(pready[k]), .pslverr(pslverr[k]), .irq(irq[k]));
    end
    mhub_chk #(.JAM_BITS_P(JB), .COL_BITS_P(CB)) i_mhub_chk (.pclk(pclk), .presetn(presetn),
        .up(i_mhub_link_if.up), .down(i_mhub_link_if.down), .uplink_disable(uplink_disable),
        .act_ind(act_ind), .col_ind(col_ind), .jam_indicator(jam_indicator),
        .config_fail_indicator(config_fail_indicator));

    // Sticky monitors, cleared by each scenario's reset
    always @(posedge pclk)
    begin
        jam_seen <= presetn && (jam_seen || jam_indicator === 1'b1);
        col_seen <= presetn ? (col_seen | col_ind) : '0;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; holds the request until pready
    task automatic apb(int n, logic wr, logic [7:0] a, logic [31:0] d);
        psel[n] <= 1'b1;
        pwrite[n] <= wr;
        paddr[n] <= a;
        pwdata[n] <= d;
        @(posedge pclk);
        penable[n] <= 1'b1;
        @(posedge pclk);
        while (pready[n] !== 1'b1)
            @(posedge pclk);
        rd = prdata[n];
        er = pslverr[n];
        psel[n] <= 1'b0;
        penable[n] <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic do_reset(logic strap);
        @(posedge pclk);
        presetn <= 1'b0;
        uplink_disable <= strap;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic wait_irq(int n);
        int i;
        i = 0;
        while (irq[n] !== 1'b1 && i < 20000)
        begin
            @(posedge pclk);
            i++;
        end
        check(irq[n], 1'b1);
    endtask

    // Activity ends two bit times after the last edge on any channel
    task automatic wait_idle();
        int i;
        i = 0;
        while (act_ind !== '0 && i < 4000)
        begin
            @(posedge pclk);
            i++;
        end
        check(act_ind, '0);
    endtask

    task automatic send(int n, logic [7:0] d);
        apb(n, 1'b1, REG_MASK, 32'h0000_0001);
        apb(n, 1'b1, REG_TXDATA, {24'h00_0000, d});
        apb(n, 1'b1, REG_CTRL, 32'h0000_0001);
    endtask

    task automatic t_regs();
        do_reset(1'b0);
        apb(1, 1'b0, REG_MASK, 32'h0000_0000);
        check(rd[2:0], RST_MASK);
        apb(1, 1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[2:0], RST_STATUS);
        apb(1, 1'b0, REG_TXDATA, 32'h0000_0000);
        check(rd[7:0], RST_TXDATA);
        apb(1, 1'b0, 8'h14, 32'h0000_0000);
        check({rd[30:0], er}, 32'h0000_0001);
    endtask

    task automatic t_frame();
        do_reset(1'b0);
        apb(0, 1'b1, REG_MASK, 32'h0000_0002);
        apb(8, 1'b1, REG_MASK, 32'h0000_0002);
        send(1, 8'hA5);
        // Frame still pending: new data must be refused
        apb(1, 1'b1, REG_TXDATA, 32'h0000_00FF);
        apb(1, 1'b0, REG_TXDATA, 32'h0000_0000);
        check(rd[7:0], 8'hA5);
        apb(1, 1'b0, REG_CTRL, 32'h0000_0000);
        check(rd[CTRL_BUSY_BIT], 1'b1);
        wait_irq(1);
        wait_irq(8);
        wait_irq(0);
        apb(8, 1'b0, REG_RXDATA, 32'h0000_0000);
        check(rd[7:0], 8'hA5);
        apb(0, 1'b0, REG_RXDATA, 32'h0000_0000);
        check(rd[7:0], 8'hA5);
        check(jam_seen, 1'b0);
        apb(1, 1'b1, REG_STATUS, 32'h0000_0007);
        check(irq[1], 1'b0);
        wait_idle();
    endtask

    // Both nodes start on the same edge, so the hub must see a collision
    task automatic t_collide();
        do_reset(1'b0);
        fork
            send(1, 8'h3C);
            send(2, 8'hC3);
        join
        wait_irq(1);
        wait_irq(2);
        check(jam_seen, 1'b1);
        check(col_seen[2:1], 2'b11);
        apb(1, 1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[ST_COL], 1'b1);
        wait_idle();
    endtask

    task automatic t_uplink();
        do_reset(1'b1);
        apb(0, 1'b1, REG_MASK, 32'h0000_0002);
        apb(8, 1'b1, REG_MASK, 32'h0000_0002);
        send(1, 8'h5A);
        wait_irq(1);
        wait_irq(8);
        wait_idle();
        apb(0, 1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[ST_RXDONE], 1'b0);
        apb(8, 1'b1, REG_STATUS, 32'h0000_0007);
        send(0, 8'h77);
        wait_irq(0);
        wait_idle();
        apb(8, 1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[ST_RXDONE], 1'b0);
        uplink_disable <= 1'b0;
        repeat (20) @(posedge pclk);
        check(config_fail_indicator, 1'b1);
        do_reset(1'b0);
        check(config_fail_indicator, 1'b0);
    endtask

    initial
    begin
        t_regs();
        t_frame();
        t_collide();
        t_uplink();
        report_and_stop();
    end

    initial
    begin
        #(80000 * 20);
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
